/* atxagc_defs.vh */
// Offsets, field positions, reset values and timing for the audio tx / gain control bank
`ifndef ATXAGC_DEFS_VH
`define ATXAGC_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ATXAGC_OFS_TX_CONFIG 8'h08
`define ATXAGC_OFS_AMP_THR 8'h09
`define ATXAGC_OFS_ATTACK_TIME 8'h0a
`define ATXAGC_OFS_RELEASE_TIME 8'h0b
`define ATXAGC_OFS_BATTERY 8'h21
`define ATXAGC_OFS_TEMPERATURE 8'h22
`define ATXAGC_OFS_BOOST_RAIL 8'h23

// ----------------------------------------
// Transmit config fields
// ----------------------------------------
`define ATXAGC_BIT_ULTRA_SLOT_MODE 13
`define ATXAGC_BIT_ULTRA_ENABLE 12
`define ATXAGC_BIT_SPLIT_PACKING 9
`define ATXAGC_BIT_LAUNCH_EDGE 8
`define ATXAGC_BIT_UNUSED_FILL 7
`define ATXAGC_BIT_UNUSED_TRISTATE 6
`define ATXAGC_BIT_INPUT_ATTEN 4
`define ATXAGC_TX_CONFIG_MASK 16'h33f7

// ----------------------------------------
// Output source codes and clock ratio codes
// ----------------------------------------
`define ATXAGC_SRC_GAIN_CONTROL 3'h0
`define ATXAGC_SRC_DATA_FIFO 3'h1
`define ATXAGC_SRC_ULTRASONIC 3'h2
`define ATXAGC_SRC_SENSE 3'h3
`define ATXAGC_SRC_SENSE_BAT_TEMP 3'h4
`define ATXAGC_BCK_RATIO_32 2'h0
`define ATXAGC_BCK_RATIO_48 2'h1
`define ATXAGC_BCK_RATIO_64 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ATXAGC_RST_TX_CONFIG 16'h0060
`define ATXAGC_RST_AMP_THR 16'h3940
`define ATXAGC_RST_ATTACK_TIME 16'h0030
`define ATXAGC_RST_RELEASE_TIME 16'h01e0
`define ATXAGC_RST_BATTERY 10'h263
`define ATXAGC_RST_TEMPERATURE 10'h019
`define ATXAGC_RST_BOOST_RAIL 10'h263

// ----------------------------------------
// Timing: one threshold unit in ns, and in mclk cycles at 100 MHz
// ----------------------------------------
`define ATXAGC_TIME_UNIT_NS 20800
`define ATXAGC_CLK_PERIOD_NS 10
// Sized so it meets the 16 bit unit counter without truncation; 20800 ns / 10 ns
`define ATXAGC_TIME_UNIT_CYC 16'd2080

`endif

/* atxagc_gain_timer.v */
// Hardware gain control attack / release timing engine
`timescale 1ns/1ns
`default_nettype none
`include "atxagc_defs.vh"

module atxagc_gain_timer #(
   parameter [15:0] UNIT_CYCLES = `ATXAGC_TIME_UNIT_CYC
) (
   input wire mclk,
   input wire rst,
   input wire level_detect_mode,
   input wire [7:0] peak_level,
   input wire [7:0] rms_level,
   input wire [7:0] attack_level_threshold,
   input wire [7:0] release_level_threshold,
   input wire [15:0] attack_time_threshold,
   input wire [15:0] release_time_threshold,
   output wire gain_reduce
);

   localparam [1:0] ST_NORMAL = 2'b01;
   localparam [1:0] ST_REDUCE = 2'b10;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [15:0] unit_ff;
   reg [15:0] nxt_unit;
   reg [15:0] run_ff;
   reg [15:0] nxt_run;
   wire [7:0] level;
   wire unit_tick;
   wire [15:0] attack_len;
   wire [15:0] release_len;

   // ----------------------------------------
   // Level and time base
   // ----------------------------------------
   assign level = level_detect_mode ? rms_level : peak_level;
   assign unit_tick = (unit_ff == UNIT_CYCLES - 16'h0001);
   // Zero is reserved; treated as one unit so the engine never fires instantly
   assign attack_len = (attack_time_threshold == 16'h0000) ? 16'h0001 : attack_time_threshold;
   assign release_len = (release_time_threshold == 16'h0000) ? 16'h0001 : release_time_threshold;
   assign gain_reduce = state_ff[1];

   // ----------------------------------------
   // Attack / release state machine
   // ----------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_run = run_ff;
      nxt_unit = unit_tick ? 16'h0000 : unit_ff + 16'h0001;
      case (state_ff)
         ST_NORMAL: begin
            if (level <= attack_level_threshold) begin
               nxt_run = 16'h0000;
            end else if (unit_tick) begin
               if (run_ff + 16'h0001 >= attack_len) begin
                  nxt_state = ST_REDUCE;
                  nxt_run = 16'h0000;
               end else begin
                  nxt_run = run_ff + 16'h0001;
               end
            end
         end
         ST_REDUCE: begin
            if (level >= release_level_threshold) begin
               nxt_run = 16'h0000;
            end else if (unit_tick) begin
               if (run_ff + 16'h0001 >= release_len) begin
                  nxt_state = ST_NORMAL;
                  nxt_run = 16'h0000;
               end else begin
                  nxt_run = run_ff + 16'h0001;
               end
            end
         end
         default: begin
            nxt_state = ST_NORMAL;
            nxt_run = 16'h0000;
         end
      endcase
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_NORMAL;
         unit_ff <= 16'h0000;
         run_ff <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         unit_ff <= nxt_unit;
         run_ff <= nxt_run;
      end
   end

endmodule
`default_nettype wire

/* atxagc_regs.v */
// Audio transmit config, gain control thresholds and measurement readback bank
`timescale 1ns/1ns
`default_nettype none
`include "atxagc_defs.vh"

module atxagc_regs (
   input wire mclk,
   input wire rst,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire [15:0] reg_wdata,
   input wire reg_rd,
   output reg [15:0] reg_rdata_ff,
   output reg reg_ack_ff,
   input wire level_detect_mode,
   input wire [1:0] bitclock_ratio,
   input wire [7:0] peak_level,
   input wire [7:0] rms_level,
   output wire gain_reduce,
   input wire meas_valid,
   input wire [9:0] battery_voltage_code,
   input wire [9:0] die_temperature_code,
   input wire [9:0] boost_rail_code,
   input wire rx_valid,
   input wire [15:0] rx_sample,
   output reg [15:0] rx_sample_ff,
   input wire slot_load,
   input wire slot_selected,
   input wire slot_ultrasonic,
   input wire slot_right,
   input wire [15:0] gain_control_output,
   input wire [15:0] data_fifo_output,
   input wire [15:0] ultrasonic_sample,
   input wire [15:0] sense_current,
   input wire [15:0] sense_voltage,
   output reg [15:0] tx_word_ff,
   output reg tx_oe_n_ff,
   output wire tx_launch_edge
);

   reg [15:0] tx_config_ff;
   reg [15:0] amp_thr_ff;
   reg [15:0] attack_time_ff;
   reg [15:0] release_time_ff;
   reg [9:0] battery_ff;
   reg [9:0] temperature_ff;
   reg [9:0] boost_rail_ff;
   reg [15:0] nxt_rdata;
   reg [15:0] legacy_word;
   reg [15:0] nxt_tx_word;
   reg nxt_tx_oe_n;
   wire ultrasonic_enable;
   wire ultrasonic_slot_mode;
   wire sense_split_packing;
   wire unused_channel_fill;
   wire unused_channel_tristate;
   wire input_attenuate;
   wire [2:0] legacy_output_source;
   wire [16:0] mix_sum;
   wire [15:0] mixed_word;
   wire split_active;
   wire [15:0] sense_word;
   wire ultra_slot_hit;
   wire unused_slot;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Saturating add keeps a mixed tone from wrapping into a full scale click
   function [15:0] atxagc_sat;
      input [16:0] sum;
      begin
         if (sum[16] != sum[15]) begin
            atxagc_sat = sum[16] ? 16'h8000 : 16'h7fff;
         end else begin
            atxagc_sat = sum[15:0];
         end
      end
   endfunction

   function atxagc_hit;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         atxagc_hit = (addr == ofs);
      end
   endfunction

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   assign ultrasonic_slot_mode = tx_config_ff[`ATXAGC_BIT_ULTRA_SLOT_MODE];
   assign ultrasonic_enable = tx_config_ff[`ATXAGC_BIT_ULTRA_ENABLE];
   assign sense_split_packing = tx_config_ff[`ATXAGC_BIT_SPLIT_PACKING];
   assign tx_launch_edge = tx_config_ff[`ATXAGC_BIT_LAUNCH_EDGE];
   assign unused_channel_fill = tx_config_ff[`ATXAGC_BIT_UNUSED_FILL];
   assign unused_channel_tristate = tx_config_ff[`ATXAGC_BIT_UNUSED_TRISTATE];
   assign input_attenuate = tx_config_ff[`ATXAGC_BIT_INPUT_ATTEN];
   assign legacy_output_source = tx_config_ff[2:0];

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Reserved bits are masked so they always read back as zero
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_config_ff <= `ATXAGC_RST_TX_CONFIG;
         amp_thr_ff <= `ATXAGC_RST_AMP_THR;
         attack_time_ff <= `ATXAGC_RST_ATTACK_TIME;
         release_time_ff <= `ATXAGC_RST_RELEASE_TIME;
      end else if (reg_wr) begin
         if (atxagc_hit(reg_addr, `ATXAGC_OFS_TX_CONFIG)) begin
            tx_config_ff <= reg_wdata & `ATXAGC_TX_CONFIG_MASK;
         end
         if (atxagc_hit(reg_addr, `ATXAGC_OFS_AMP_THR)) begin
            amp_thr_ff <= reg_wdata;
         end
         if (atxagc_hit(reg_addr, `ATXAGC_OFS_ATTACK_TIME)) begin
            attack_time_ff <= reg_wdata;
         end
         if (atxagc_hit(reg_addr, `ATXAGC_OFS_RELEASE_TIME)) begin
            release_time_ff <= reg_wdata;
         end
      end
   end

   // ----------------------------------------
   // Measurement capture
   // ----------------------------------------
   // Writes to these offsets are ignored; only the converters update them
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         battery_ff <= `ATXAGC_RST_BATTERY;
         temperature_ff <= `ATXAGC_RST_TEMPERATURE;
         boost_rail_ff <= `ATXAGC_RST_BOOST_RAIL;
      end else if (meas_valid) begin
         battery_ff <= battery_voltage_code;
         temperature_ff <= die_temperature_code;
         boost_rail_ff <= boost_rail_code;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always @* begin
      nxt_rdata = 16'h0000;
      case (reg_addr)
         `ATXAGC_OFS_TX_CONFIG: begin
            nxt_rdata = tx_config_ff;
         end
         `ATXAGC_OFS_AMP_THR: begin
            nxt_rdata = amp_thr_ff;
         end
         `ATXAGC_OFS_ATTACK_TIME: begin
            nxt_rdata = attack_time_ff;
         end
         `ATXAGC_OFS_RELEASE_TIME: begin
            nxt_rdata = release_time_ff;
         end
         `ATXAGC_OFS_BATTERY: begin
            nxt_rdata = {6'h00, battery_ff};
         end
         `ATXAGC_OFS_TEMPERATURE: begin
            nxt_rdata = {6'h00, temperature_ff};
         end
         `ATXAGC_OFS_BOOST_RAIL: begin
            nxt_rdata = {6'h00, boost_rail_ff};
         end
         default: begin
            nxt_rdata = 16'h0000;
         end
      endcase
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata_ff <= 16'h0000;
         reg_ack_ff <= 1'b0;
      end else begin
         reg_ack_ff <= reg_rd | reg_wr;
         if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

   // ----------------------------------------
   // Receive path attenuation
   // ----------------------------------------
   // Arithmetic halving is -6.02 dB, close enough and free of multipliers
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_sample_ff <= 16'h0000;
      end else if (rx_valid) begin
         rx_sample_ff <= input_attenuate ? {rx_sample[15], rx_sample[15:1]} : rx_sample;
      end
   end

   // ----------------------------------------
   // Transmit word selection
   // ----------------------------------------
   assign mix_sum = {gain_control_output[15], gain_control_output} +
                    {ultrasonic_sample[15], ultrasonic_sample};
   assign mixed_word = atxagc_sat(mix_sum);
   assign split_active = sense_split_packing && (bitclock_ratio == `ATXAGC_BCK_RATIO_32);

   // ----------------------------------------
   // Slot classification
   // ----------------------------------------
   // Split packing at the 32 bit clock ratio owns both channels, so no slot counts as unused then
   assign sense_word = slot_right ? sense_voltage : sense_current;
   assign ultra_slot_hit = ultrasonic_enable && ultrasonic_slot_mode && slot_ultrasonic;
   assign unused_slot = !slot_selected && !split_active && !ultra_slot_hit;

   always @* begin
      legacy_word = 16'h0000;
      case (legacy_output_source)
         `ATXAGC_SRC_GAIN_CONTROL: begin
            legacy_word = (ultrasonic_enable && !ultrasonic_slot_mode) ?
                          mixed_word : gain_control_output;
         end
         `ATXAGC_SRC_DATA_FIFO: begin
            legacy_word = data_fifo_output;
         end
         `ATXAGC_SRC_ULTRASONIC: begin
            legacy_word = ultrasonic_sample;
         end
         `ATXAGC_SRC_SENSE: begin
            legacy_word = sense_word;
         end
         `ATXAGC_SRC_SENSE_BAT_TEMP: begin
            legacy_word = slot_right ? {sense_voltage[15:8], temperature_ff[9:2]} :
                          {sense_current[15:8], battery_ff[9:2]};
         end
         default: begin
            // Undefined codes send silence rather than stale data
            legacy_word = 16'h0000;
         end
      endcase
   end

   always @* begin
      nxt_tx_word = legacy_word;
      nxt_tx_oe_n = 1'b0;
      if (split_active) begin
         nxt_tx_word = sense_word;
      end
      if (ultra_slot_hit) begin
         nxt_tx_word = ultrasonic_sample;
      end else if (unused_slot) begin
         nxt_tx_word = unused_channel_fill ? legacy_word : 16'h0000;
         nxt_tx_oe_n = unused_channel_tristate;
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_word_ff <= 16'h0000;
         tx_oe_n_ff <= 1'b1;
      end else if (slot_load) begin
         tx_word_ff <= nxt_tx_word;
         tx_oe_n_ff <= nxt_tx_oe_n;
      end
   end

   // ----------------------------------------
   // Gain control timing
   // ----------------------------------------
   atxagc_gain_timer u_gain_timer (
      .mclk(mclk),
      .rst(rst),
      .level_detect_mode(level_detect_mode),
      .peak_level(peak_level),
      .rms_level(rms_level),
      .attack_level_threshold(amp_thr_ff[7:0]),
      .release_level_threshold(amp_thr_ff[15:8]),
      .attack_time_threshold(attack_time_ff),
      .release_time_threshold(release_time_ff),
      .gain_reduce(gain_reduce)
   );

endmodule
`default_nettype wire

/* atxagc_regs_assertions.sv */
// Concurrent checks on the audio tx and gain control register bank ports
`timescale 1ns/1ns
`default_nettype none
module atxagc_regs_checker (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata_ff,
   input wire logic reg_ack_ff,
   input wire logic rx_valid,
   input wire logic [15:0] rx_sample_ff,
   input wire logic slot_load,
   input wire logic slot_selected,
   input wire logic [15:0] tx_word_ff,
   input wire logic tx_oe_n_ff,
   input wire logic tx_launch_edge
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Bus steps
   // ----------------------------------------
   sequence s_cfg_wr;
      reg_wr && !reg_rd && reg_addr == 8'h08;
   endsequence
   sequence s_cfg_rd;
      reg_rd && !reg_wr && reg_addr == 8'h08;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   ack_follows_a: assert property ((reg_rd || reg_wr) |=> reg_ack_ff)
      else $error("ack missing after strobe");
   ack_quiet_a: assert property (!(reg_rd || reg_wr) |=> !reg_ack_ff)
      else $error("ack without strobe");
   cfg_mask_a: assert property (
      s_cfg_wr ##1 !reg_wr ##1 s_cfg_rd |=> reg_rdata_ff == ($past(reg_wdata, 3) & 16'h33f7))
      else $error("config readback mismatch");
   unmapped_zero_a: assert property (
      reg_rd && !(reg_addr inside {8'h08, 8'h09, 8'h0a, 8'h0b, 8'h21, 8'h22, 8'h23})
      |=> reg_rdata_ff == 16'h0000)
      else $error("unmapped read not zero");
   meas_upper_a: assert property (
      reg_rd && reg_addr inside {8'h21, 8'h22, 8'h23} |=> reg_rdata_ff[15:10] == 6'h00)
      else $error("measurement upper bits not zero");
   edge_follow_a: assert property (
      s_cfg_wr |=> tx_launch_edge == $past(reg_wdata[8]))
      else $error("launch edge not following bit 8");
   edge_hold_a: assert property (
      !(reg_wr && reg_addr == 8'h08) |=> $stable(tx_launch_edge))
      else $error("launch edge changed without write");
   slot_hold_a: assert property (
      !slot_load |=> $stable(tx_word_ff) && $stable(tx_oe_n_ff))
      else $error("tx slot output changed without load");
   selected_drive_a: assert property (slot_load && slot_selected |=> !tx_oe_n_ff)
      else $error("selected slot not driven");
   rx_hold_a: assert property (!rx_valid |=> $stable(rx_sample_ff))
      else $error("rx sample changed without valid");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_ff))
      else $error("read data changed without read");
endmodule

bind atxagc_regs atxagc_regs_checker u_chk (
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .reg_ack_ff(reg_ack_ff),
   .rx_valid(rx_valid), .rx_sample_ff(rx_sample_ff), .slot_load(slot_load),
   .slot_selected(slot_selected), .tx_word_ff(tx_word_ff), .tx_oe_n_ff(tx_oe_n_ff),
   .tx_launch_edge(tx_launch_edge)
);
`default_nettype wire

/* tb_atxagc_regs.sv */
// Self-checking testbench for the audio tx and gain control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_atxagc_regs;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rx_valid = 1'b0, meas_valid = 1'b0;
   logic [15:0] reg_wdata = 16'h0000, rx_sample = 16'h8004;
   logic level_detect_mode = 1'b0;
   logic [1:0] bitclock_ratio = 2'h2;
   logic [7:0] peak_level = 8'h00, rms_level = 8'h00;
   logic [9:0] bat_code = 10'h3ff, temp_code = 10'h3d8, rail_code = 10'h001;
   logic slot_load = 1'b0, slot_selected = 1'b0, slot_ultrasonic = 1'b0, slot_right = 1'b0;
   logic [15:0] gain_out = 16'h1111, fifo_out = 16'h2222, ultra_in = 16'h3333;
   logic [15:0] cur_in = 16'h44aa, volt_in = 16'h4455;
   // Code 4 low byte is battery reset code bits 9:2
   logic [15:0] src_exp [8] = '{16'h1111, 16'h2222, 16'h3333, 16'h44aa, 16'h4498,
                                16'h0000, 16'h0000, 16'h0000};
   wire [15:0] reg_rdata_ff, rx_sample_ff, tx_word_ff;
   wire reg_ack_ff, gain_reduce, tx_oe_n_ff, tx_launch_edge;
   int fails = 0, samples_checked = 0;
   int i;

   always #5 mclk = ~mclk;

   atxagc_regs u_dut (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .reg_ack_ff(reg_ack_ff),
      .level_detect_mode(level_detect_mode), .bitclock_ratio(bitclock_ratio),
      .peak_level(peak_level), .rms_level(rms_level), .gain_reduce(gain_reduce),
      .meas_valid(meas_valid), .battery_voltage_code(bat_code),
      .die_temperature_code(temp_code), .boost_rail_code(rail_code),
      .rx_valid(rx_valid), .rx_sample(rx_sample), .rx_sample_ff(rx_sample_ff),
      .slot_load(slot_load), .slot_selected(slot_selected),
      .slot_ultrasonic(slot_ultrasonic), .slot_right(slot_right),
      .gain_control_output(gain_out), .data_fifo_output(fifo_out),
      .ultrasonic_sample(ultra_in), .sense_current(cur_in), .sense_voltage(volt_in),
      .tx_word_ff(tx_word_ff), .tx_oe_n_ff(tx_oe_n_ff), .tx_launch_edge(tx_launch_edge)
   );

   // ----------------------------------------
   // Access tasks, entered and left at a falling edge
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      check("write ack", 16'h0001, {15'h0, reg_ack_ff});
      @(negedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      check("ack", 16'h0001, {15'h0, reg_ack_ff});
      check($sformatf("reg %h", a), exp, reg_rdata_ff);
      @(negedge mclk);
   endtask

   task automatic slot(input logic sel, us, right, input logic [15:0] w, input logic oe_n);
      slot_selected = sel;
      slot_ultrasonic = us;
      slot_right = right;
      slot_load = 1'b1;
      @(negedge mclk);
      slot_load = 1'b0;
      check("tx word", w, tx_word_ff);
      check("tx oe_n", {15'h0, oe_n}, {15'h0, tx_oe_n_ff});
      @(negedge mclk);
   endtask

   task automatic rx(input logic [15:0] exp);
      rx_valid = 1'b1;
      @(negedge mclk);
      rx_valid = 1'b0;
      check("rx sample", exp, rx_sample_ff);
      @(negedge mclk);
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      rd(8'h08, 16'h0060);
      rd(8'h09, 16'h3940);
      rd(8'h0a, 16'h0030);
      rd(8'h0b, 16'h01e0);
      rd(8'h21, 16'h0263);
      rd(8'h22, 16'h0019);
      rd(8'h23, 16'h0263);
      rd(8'h30, 16'h0000);
      slot(1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
      wr(8'h21, 16'h0000);
      rd(8'h21, 16'h0263);
      wr(8'h08, 16'hffff);
      rd(8'h08, 16'h33f7);
      check("launch edge", 16'h0001, {15'h0, tx_launch_edge});
      wr(8'h08, 16'h0000);
      check("launch edge", 16'h0000, {15'h0, tx_launch_edge});
      slot(1'b0, 1'b0, 1'b0, 16'h0000, 1'b0);
      wr(8'h08, 16'h0080);
      slot(1'b0, 1'b0, 1'b0, 16'h1111, 1'b0);
      for (i = 0; i < 8; i++) begin
         wr(8'h08, 16'(i));
         slot(1'b1, 1'b0, 1'b0, src_exp[i], 1'b0);
      end
      wr(8'h08, 16'h0200);
      bitclock_ratio = 2'h0;
      slot(1'b0, 1'b0, 1'b0, 16'h44aa, 1'b0);
      slot(1'b0, 1'b0, 1'b1, 16'h4455, 1'b0);
      bitclock_ratio = 2'h2;
      slot(1'b1, 1'b0, 1'b1, 16'h1111, 1'b0);
      wr(8'h08, 16'h3000);
      slot(1'b0, 1'b1, 1'b0, 16'h3333, 1'b0);
      wr(8'h08, 16'h1000);
      slot(1'b1, 1'b0, 1'b0, 16'h4444, 1'b0);
      // Positive overflow of the mix must clip to full scale
      gain_out = 16'h7000;
      slot(1'b1, 1'b0, 1'b0, 16'h7fff, 1'b0);
      wr(8'h08, 16'h0010);
      rx(16'hc002);
      wr(8'h08, 16'h0000);
      rx(16'h8004);
      meas_valid = 1'b1;
      @(negedge mclk);
      meas_valid = 1'b0;
      rd(8'h21, 16'h03ff);
      rd(8'h22, 16'h03d8);
      rd(8'h23, 16'h0001);
      // Shortest legal times keep the run to a few thousand cycles
      wr(8'h0a, 16'h0001);
      wr(8'h0b, 16'h0001);
      peak_level = 8'h50;
      for (i = 0; i < 6000 && gain_reduce !== 1'b1; i++) @(negedge mclk);
      check("gain reduce", 16'h0001, {15'h0, gain_reduce});
      // Peak stays above release level, so only the RMS path can release
      level_detect_mode = 1'b1;
      for (i = 0; i < 6000 && gain_reduce !== 1'b0; i++) @(negedge mclk);
      check("gain reduce", 16'h0000, {15'h0, gain_reduce});
      wrap_up();
   end

   initial begin
      repeat (50000) @(posedge mclk);
      fails++;
      wrap_up();
   end
endmodule
`default_nettype wire
